// [rtl/bct_cfg.svh]
// Constants for the bearer channel control error checker and retry timers.
// Assumes a 20 MHz clock; included by bare name from the three RTL modules.
`ifndef BCT_CFG_SVH
`define BCT_CFG_SVH
`define BCT_CLK_HZ 20000000
`define BCT_STEP_MS 100
`define BCT_STEP_CYC ((`BCT_CLK_HZ / 1000) * `BCT_STEP_MS)
`define BCT_TICK_DIV 10
`define BCT_REL_MS 2000
`define BCT_REL_STEPS (`BCT_REL_MS / `BCT_STEP_MS)
`define BCT_MIN_STEPS 4'h5
`define BCT_MAX_STEPS 4'hf
`define BCT_MIN_OCTETS 8'h04
`define BCT_NTMR 5
`endif

// [rtl/bct_err_timers.sv]
// Message content checker and five supervision timers of a bearer channel
// control entity. Assumes an upstream parser presents one checked message
// summary per msg_valid pulse and that the protocol engine drives the
// timer start and stop strobes; all inputs are on this clock.
`timescale 1ns/10ps
`include "bct_cfg.svh"
module bct_err_timers
  import bct_pkg::*;
#(
  parameter int STEP_CYC = `BCT_STEP_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic access_side,
  input wire logic [3:0] timeout_steps,
  input wire logic msg_valid,
  input wire logic [7:0] msg_octets,
  input wire logic mand_len_err,
  input wire logic mand_unknown,
  input wire logic opt_len_err,
  input wire logic opt_uninterp,
  input wire logic [3:0] opt_err_index,
  input wire logic msg_unexpected,
  input wire logic opt_too_many,
  input wire logic alloc_sent,
  input wire logic alloc_done,
  input wire logic alloc_abort,
  input wire logic abort_rel_sent,
  input wire logic rel_sent,
  input wire logic rel_done,
  input wire logic audit_sent,
  input wire logic audit_done,
  input wire logic fault_sent,
  input wire logic fault_ack,
  output logic msg_accept,
  output logic msg_discard,
  output logic opt_drop,
  output logic [3:0] opt_drop_index,
  output logic pe_send,
  output bct_pe_t pe_cause,
  output logic mgmt_notify_primitive,
  output bct_cause_t mgmt_cause,
  output logic alloc_resend,
  output logic abort_rel_resend,
  output logic rel_resend,
  output logic audit_resend,
  output logic fault_resend,
  output logic [4:0] timers_running
);
  logic tick;
  logic [4:0] common_steps;
  logic [4:0] start_v;
  logic [4:0] stop_v;
  logic [4:0] resend_v;
  logic [4:0] expire_v;
  logic [4:0] expire_r;
  logic [4:0] run_v;
  bct_cause_t chk_cause;
  bct_pe_t chk_pe;
  logic chk_discard;

  // Clamp the shared timeout into 500..1500 ms, in 100 ms steps.
  function automatic logic [4:0] clamp_steps(input logic [3:0] s);
    if (s < `BCT_MIN_STEPS)
      clamp_steps = {1'b0, `BCT_MIN_STEPS};
    else if (s > `BCT_MAX_STEPS)
      clamp_steps = {1'b0, `BCT_MAX_STEPS};
    else
      clamp_steps = {1'b0, s};
  endfunction

  assign common_steps = clamp_steps(timeout_steps);

  // Only the side that owns a timer may start it.
  assign start_v = {fault_sent & access_side,
                    audit_sent & ~access_side,
                    rel_sent & ~access_side,
                    abort_rel_sent & ~access_side,
                    alloc_sent & ~access_side};
  assign stop_v = {fault_ack, audit_done, rel_done, rel_done, alloc_done | alloc_abort};

  bct_step_tick #(
    .STEP_CYC(STEP_CYC)
  ) u_tick (
    .clock(clock),
    .nrst(nrst),
    .tick(tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `BCT_NTMR; gi++) begin : g_tmr
      bct_retry_timer u_tmr (
        .clock(clock),
        .nrst(nrst),
        .tick(tick),
        .start(start_v[gi]),
        .stop(stop_v[gi]),
        .steps((gi == 1 || gi == 2) ? 5'(`BCT_REL_STEPS) : common_steps),
        .running(run_v[gi]),
        .resend(resend_v[gi]),
        .expire(expire_v[gi])
      );
    end
  endgenerate

  // First failing check in precedence order decides the outcome.
  always_comb begin
    chk_cause = BCT_CAUSE_NONE;
    chk_pe = BCT_PE_NONE;
    chk_discard = 1'b0;
    if (msg_octets < `BCT_MIN_OCTETS) begin
      chk_cause = BCT_CAUSE_SHORT_MSG;
      chk_discard = 1'b1;
    end else if (mand_len_err || mand_unknown) begin
      chk_cause = BCT_CAUSE_MAND_CONTENT;
      chk_pe = BCT_PE_MAND_CONTENT;
      chk_discard = 1'b1;
    end else if (opt_len_err || opt_uninterp) begin
      chk_cause = BCT_CAUSE_OPT_CONTENT;
      chk_pe = BCT_PE_OPT_CONTENT;
    end else if (msg_unexpected) begin
      chk_cause = BCT_CAUSE_STATE_INCOMPAT;
      chk_pe = BCT_PE_STATE_INCOMPAT;
      chk_discard = 1'b1;
    end else if (opt_too_many) begin
      chk_cause = BCT_CAUSE_TOO_MANY;
      chk_pe = BCT_PE_TOO_MANY;
      chk_discard = 1'b1;
    end
  end

  // Verdict is registered; the caller holds protocol state until it arrives.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      msg_accept <= 1'b0;
      msg_discard <= 1'b0;
      opt_drop <= 1'b0;
      opt_drop_index <= 4'h0;
      pe_send <= 1'b0;
      pe_cause <= BCT_PE_NONE;
    end else begin
      msg_accept <= msg_valid && !chk_discard;
      msg_discard <= msg_valid && chk_discard;
      opt_drop <= msg_valid && (chk_cause == BCT_CAUSE_OPT_CONTENT);
      opt_drop_index <= msg_valid ? opt_err_index : 4'h0;
      pe_send <= msg_valid && access_side && (chk_pe != BCT_PE_NONE);
      pe_cause <= (msg_valid && access_side) ? chk_pe : BCT_PE_NONE;
    end
  end

  // Timer resends are registered once more; conclusions wait behind errors until a cycle has none.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      alloc_resend <= 1'b0;
      abort_rel_resend <= 1'b0;
      rel_resend <= 1'b0;
      audit_resend <= 1'b0;
      fault_resend <= 1'b0;
      timers_running <= 5'h0;
    end else begin
      alloc_resend <= resend_v[0];
      abort_rel_resend <= resend_v[1];
      rel_resend <= resend_v[2];
      audit_resend <= resend_v[3];
      fault_resend <= resend_v[4];
      timers_running <= run_v;
    end
  end

  // Pending timer conclusions; a new expiry is kept even while one is sent.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      expire_r <= 5'h0;
      mgmt_notify_primitive <= 1'b0;
      mgmt_cause <= BCT_CAUSE_NONE;
    end else begin
      mgmt_notify_primitive <= 1'b0;
      mgmt_cause <= BCT_CAUSE_NONE;
      if (msg_valid && chk_cause != BCT_CAUSE_NONE) begin
        mgmt_notify_primitive <= 1'b1;
        mgmt_cause <= chk_cause;
        expire_r <= expire_r | expire_v;
      end else if ((expire_r | expire_v) != 5'h0) begin
        mgmt_notify_primitive <= 1'b1;
        priority casez (expire_r | expire_v)
          5'b????1: begin
            mgmt_cause <= BCT_CAUSE_ALLOC_FAIL;
            expire_r <= (expire_r | expire_v) & 5'h1e;
          end
          5'b???10: begin
            mgmt_cause <= BCT_CAUSE_ABORT_REL_FAIL;
            expire_r <= (expire_r | expire_v) & 5'h1c;
          end
          5'b??100: begin
            mgmt_cause <= BCT_CAUSE_REL_FAIL;
            expire_r <= (expire_r | expire_v) & 5'h18;
          end
          5'b?1000: begin
            mgmt_cause <= BCT_CAUSE_AUDIT_FAIL;
            expire_r <= (expire_r | expire_v) & 5'h10;
          end
          default: begin
            mgmt_cause <= BCT_CAUSE_FAULT_FAIL;
            expire_r <= 5'h0;
          end
        endcase
      end
    end
  end
endmodule // bct_err_timers

// [rtl/bct_pkg.sv]
// Types shared by the error checker and the retry timers.
// Assumes bct_cfg.svh is on the include path.
package bct_pkg;
  typedef enum logic [3:0] {
    BCT_CAUSE_NONE,
    BCT_CAUSE_SHORT_MSG,
    BCT_CAUSE_MAND_CONTENT,
    BCT_CAUSE_OPT_CONTENT,
    BCT_CAUSE_STATE_INCOMPAT,
    BCT_CAUSE_TOO_MANY,
    BCT_CAUSE_ALLOC_FAIL,
    BCT_CAUSE_ABORT_REL_FAIL,
    BCT_CAUSE_REL_FAIL,
    BCT_CAUSE_AUDIT_FAIL,
    BCT_CAUSE_FAULT_FAIL
  } bct_cause_t;
  typedef enum logic [2:0] {
    BCT_PE_NONE,
    BCT_PE_MAND_CONTENT,
    BCT_PE_OPT_CONTENT,
    BCT_PE_STATE_INCOMPAT,
    BCT_PE_TOO_MANY
  } bct_pe_t;
endpackage

// [rtl/bct_retry_timer.sv]
// One supervision timer: start, stop, retry once, then conclude.
// Assumes a step tick from bct_step_tick on the same clock.
`timescale 1ns/10ps
`include "bct_cfg.svh"
module bct_retry_timer
  import bct_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [4:0] steps,
  output logic running,
  output logic resend,
  output logic expire
);
  logic [7:0] left_r;
  logic second_r;
  logic hit;

  // Ticks per timeout; loaded on start and again on the first expiry.
  function automatic logic [7:0] load_ticks(input logic [4:0] s);
    load_ticks = 8'(s) * 8'(`BCT_TICK_DIV);
  endfunction

  assign hit = running && tick && (left_r == 8'h1);

  // Start wins over stop; the first expiry reloads, the second concludes.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      running <= 1'b0;
      second_r <= 1'b0;
      left_r <= 8'h0;
      resend <= 1'b0;
      expire <= 1'b0;
    end else begin
      resend <= 1'b0;
      expire <= 1'b0;
      if (start) begin
        running <= 1'b1;
        second_r <= 1'b0;
        left_r <= load_ticks(steps);
      end else if (stop) begin
        running <= 1'b0;
      end else if (hit && !second_r) begin
        resend <= 1'b1;
        second_r <= 1'b1;
        left_r <= load_ticks(steps);
      end else if (hit) begin
        expire <= 1'b1;
        running <= 1'b0;
      end else if (running && tick) begin
        left_r <= left_r - 8'h1;
      end
    end
  end
endmodule // bct_retry_timer

// [rtl/bct_step_tick.sv]
// Free running tick at a tenth of the 100 ms step for the retry timers.
// Assumes one 20 MHz clock and a synchronous active low reset.
`timescale 1ns/10ps
`include "bct_cfg.svh"
module bct_step_tick #(
  parameter int STEP_CYC = `BCT_STEP_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  output logic tick
);
  localparam int TICK_CYC = STEP_CYC / `BCT_TICK_DIV;
  logic [31:0] cnt_r;

  // A free running tick starts each timer at an unknown phase.
  // Ticking ten times per step keeps that error to a tenth of one step.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_r == 32'(TICK_CYC - 1)) begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // bct_step_tick

// [verif/bct_err_timers_asserts.sv]
// Port checker for the message checker and retry timers.
// Bound to bct_err_timers; sees only its ports.
`timescale 1ns/10ps
module bct_err_timers_asserts
  import bct_pkg::*;
#(
  parameter int STEP_CYC = 20
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic access_side,
  input wire logic [3:0] timeout_steps,
  input wire logic msg_valid,
  input wire logic [7:0] msg_octets,
  input wire logic mand_len_err,
  input wire logic mand_unknown,
  input wire logic opt_len_err,
  input wire logic opt_uninterp,
  input wire logic [3:0] opt_err_index,
  input wire logic msg_unexpected,
  input wire logic opt_too_many,
  input wire logic alloc_sent,
  input wire logic msg_accept,
  input wire logic msg_discard,
  input wire logic opt_drop,
  input wire logic [3:0] opt_drop_index,
  input wire logic pe_send,
  input wire logic mgmt_notify_primitive,
  input bct_cause_t mgmt_cause,
  input wire logic alloc_resend
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  logic [2:0] fe;
  logic [31:0] cnt_r;
  wire [31:0] nom = 32'(timeout_steps) * STEP_CYC;
  // First error of a message by precedence, 6 when clean.
  assign fe = !msg_valid ? 3'h0 : msg_octets < 8'h04 ? 3'h1 : mand_len_err | mand_unknown ? 3'h2 :
    opt_len_err | opt_uninterp ? 3'h3 : msg_unexpected ? 3'h4 : opt_too_many ? 3'h5 : 3'h6;
  always_ff @(posedge clock) begin
    if (!nrst || alloc_sent || alloc_resend) cnt_r <= 32'h0;
    else cnt_r <= cnt_r + 32'h1;
  end
  cause_map_a: assert property (fe inside {[3'h1:3'h5]} |=> mgmt_notify_primitive &&
    mgmt_cause == $past(fe)) else $error("wrong cause");
  discard_msg_a: assert property (fe inside {3'h1, 3'h2, 3'h4, 3'h5} |=>
    msg_discard && !msg_accept) else $error("no discard");
  pe_side_a: assert property (fe inside {[3'h2:3'h5]} |=> pe_send == access_side)
    else $error("wrong error send");
  short_quiet_a: assert property (fe == 3'h1 |=> !pe_send)
    else $error("short msg sent error");
  opt_drop_a: assert property (fe == 3'h3 |=> msg_accept && opt_drop &&
    opt_drop_index == $past(opt_err_index)) else $error("opt drop");
  clean_msg_a: assert property (fe == 3'h6 |=> msg_accept && !msg_discard && !pe_send)
    else $error("clean msg");
  notify_cause_a: assert property (mgmt_notify_primitive == (mgmt_cause != BCT_CAUSE_NONE))
    else $error("notify cause");
  alloc_time_a: assert property (alloc_resend || mgmt_cause == BCT_CAUSE_ALLOC_FAIL |->
    cnt_r * 32'ha >= nom * 32'h9 && cnt_r * 32'ha <= nom * 32'hb + 32'h50) else $error("alloc time");
endmodule // bct_err_timers_asserts

bind bct_err_timers bct_err_timers_asserts #(.STEP_CYC(STEP_CYC)) u_bct_err_timers_asserts (.*);

// [verif/bct_peer_model.sv]
// Peer entity: answers a request after a set delay, or never when it is 0.
// Assumes one-cycle request pulses on the bench clock.
`timescale 1ns/10ps
module bct_peer_model (
  input wire logic clock,
  input wire logic req,
  input wire logic [11:0] delay,
  output logic ans
);
  int cnt = 0;
  initial ans = 1'h0;
  always @(posedge clock) begin
    if (req && cnt == 0 && delay != 12'h0) cnt <= delay;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  // Answer stops the timer.
  always @(negedge clock) ans <= cnt == 1;
endmodule // bct_peer_model

// [verif/testbench.sv]
// Self-checking bench for bct_err_timers with peer models.
// Assumes the checker is bound by its own file.
`timescale 1ns/10ps
module testbench;
  import bct_pkg::*;
  localparam int STEP_CYC = 20;
  logic clock = 1'h0, nrst = 1'h0, access_side = 1'h1, msg_valid = 1'h0, alloc_abort = 1'h0;
  logic mand_len_err = 1'h0, mand_unknown = 1'h0, opt_len_err = 1'h0, opt_uninterp = 1'h0;
  logic msg_unexpected = 1'h0, opt_too_many = 1'h0;
  logic [3:0] timeout_steps = 4'h5, opt_err_index = 4'h0, opt_drop_index;
  logic [7:0] msg_octets = 8'h0;
  logic [4:0] st = 5'h0, timers_running;
  logic [11:0] dly = 12'h0;
  wire alloc_sent = st[0], abort_rel_sent = st[1], rel_sent = st[2];
  wire audit_sent = st[3], fault_sent = st[4];
  logic alloc_done, rel_done, audit_done, fault_ack, msg_accept, msg_discard, opt_drop, pe_send;
  logic mgmt_notify_primitive, alloc_resend, abort_rel_resend, rel_resend, audit_resend;
  logic fault_resend;
  bct_pe_t pe_cause;
  bct_cause_t mgmt_cause;
  logic [14:0] vq[$];
  logic [4:0] eq[$];
  int err_total = 0, tests_run = 0;
  wire [4:0] rs = {fault_resend, audit_resend, rel_resend, abort_rel_resend, alloc_resend};
  wire [14:0] vgot = {msg_accept, msg_discard, opt_drop, opt_drop ? opt_drop_index : 4'h0,
    pe_send, pe_cause, mgmt_cause};
  bct_err_timers #(.STEP_CYC(STEP_CYC)) u_bct_err_timers (.*);
  bct_peer_model u_bct_peer_model_a (.clock(clock), .req(alloc_sent | alloc_resend), .delay(dly),
    .ans(alloc_done));
  bct_peer_model u_bct_peer_model_r (.clock(clock), .delay(dly), .ans(rel_done),
    .req(abort_rel_sent | rel_sent | abort_rel_resend | rel_resend));
  bct_peer_model u_bct_peer_model_u (.clock(clock), .req(audit_sent | audit_resend), .delay(dly),
    .ans(audit_done));
  bct_peer_model u_bct_peer_model_f (.clock(clock), .req(fault_sent | fault_resend), .delay(dly),
    .ans(fault_ack));
  always #25 clock = ~clock;

  task automatic bad(string nm, logic [14:0] e, logic [14:0] g);
    tests_run++;
    if (e !== g) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_verdict(logic [14:0] g);
    bad("verdict", vq.size() > 0 ? vq.pop_front() : 15'hx, g);
  endtask
  task automatic chk_event(logic [4:0] g);
    bad("event", {10'h0, eq.size() > 0 ? eq.pop_front() : 5'hx}, {10'h0, g});
  endtask
  task automatic chk_run(logic [4:0] g);
    bad("running", 15'h0, {10'h0, g});
  endtask
  task automatic final_report();
    if (vq.size() + eq.size() != 0) err_total++;
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(negedge clock) begin
    if (nrst) begin
      if (msg_accept || msg_discard) chk_verdict(vgot);
      for (int k = 0; k < 5; k++)
        if (rs[k]) chk_event(5'h10 + 5'(k));
      if (mgmt_cause >= BCT_CAUSE_ALLOC_FAIL) chk_event({1'h0, mgmt_cause});
    end
  end

  function automatic logic [14:0] mk(logic [2:0] v, bct_pe_t p, bct_cause_t c);
    return {v, v[0] ? opt_err_index : 4'h0, access_side && p != BCT_PE_NONE,
      access_side ? p : BCT_PE_NONE, c};
  endfunction
  task automatic msgs(int n);
    logic [14:0] e;
    repeat (n) begin
      @(negedge clock);
      msg_octets = 8'($urandom_range(12));
      opt_err_index = 4'($urandom);
      {mand_len_err, mand_unknown, opt_len_err, opt_uninterp, msg_unexpected, opt_too_many} =
        6'($urandom & $urandom & $urandom);
      if (msg_octets < 8'h04) e = mk(3'h2, BCT_PE_NONE, BCT_CAUSE_SHORT_MSG);
      else if (mand_len_err | mand_unknown) e = mk(3'h2, BCT_PE_MAND_CONTENT, BCT_CAUSE_MAND_CONTENT);
      else if (opt_len_err | opt_uninterp) e = mk(3'h5, BCT_PE_OPT_CONTENT, BCT_CAUSE_OPT_CONTENT);
      else if (msg_unexpected) e = mk(3'h2, BCT_PE_STATE_INCOMPAT, BCT_CAUSE_STATE_INCOMPAT);
      else if (opt_too_many) e = mk(3'h2, BCT_PE_TOO_MANY, BCT_CAUSE_TOO_MANY);
      else e = mk(3'h4, BCT_PE_NONE, BCT_CAUSE_NONE);
      vq.push_back(e);
      msg_valid = 1'h1;
    end
    @(negedge clock);
    msg_valid = 1'h0;
    repeat (2) @(negedge clock);
  endtask
  task automatic tmr(int k, logic [4:0] e0, logic [4:0] e1, int ab);
    int w;
    if (e0 != 5'h0) eq.push_back(e0);
    if (e1 != 5'h0) eq.push_back(e1);
    @(negedge clock);
    st[k] = 1'h1;
    @(negedge clock);
    st[k] = 1'h0;
    repeat (ab) @(negedge clock);
    alloc_abort = ab > 0;
    @(negedge clock);
    alloc_abort = 1'h0;
    w = 0;
    while ((eq.size() > 0 || timers_running != 5'h0) && w < 4000) begin
      @(negedge clock);
      w++;
    end
    chk_run(timers_running);
  endtask
  task automatic do_reset(logic side, logic [3:0] n);
    @(negedge clock);
    nrst = 1'h0;
    access_side = side;
    timeout_steps = n;
    repeat (6) @(negedge clock);
    nrst = 1'h1;
  endtask

  initial begin
    void'($urandom(32'hcfe6fa25));
    do_reset(1'h1, 4'($urandom_range(15, 5)));
    msgs(40);
    tmr(4, 5'h14, {1'h0, BCT_CAUSE_FAULT_FAIL}, 0);
    dly = 12'(timeout_steps * STEP_CYC * 3 / 2);
    tmr(4, 5'h14, 5'h0, 0);
    dly = 12'h0;
    tmr(0, 5'h0, 5'h0, 0);
    do_reset(1'h0, 4'hf);
    msgs(40);
    tmr(0, 5'h10, {1'h0, BCT_CAUSE_ALLOC_FAIL}, 0);
    tmr(0, 5'h0, 5'h0, 40);
    tmr(1, 5'h11, {1'h0, BCT_CAUSE_ABORT_REL_FAIL}, 0);
    tmr(3, 5'h13, {1'h0, BCT_CAUSE_AUDIT_FAIL}, 0);
    tmr(4, 5'h0, 5'h0, 0);
    dly = 12'h258;
    tmr(2, 5'h12, 5'h0, 0);
    dly = 12'h1e;
    tmr(0, 5'h0, 5'h0, 0);
    final_report();
  end
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    final_report();
  end
endmodule // testbench
